//--- pkg/wch_map.svh
`ifndef WCH_MAP_SVH
`define WCH_MAP_SVH

// Word and counter widths
`define WCH_DATA_W 48
`define WCH_LEN_W 16
`define WCH_CNT_W 14
`define WCH_PIN_W 4

// Bit positions of the resynchronised control pins
`define WCH_PIN_IN_READY 0
`define WCH_PIN_OUT_RESUME 1
`define WCH_PIN_INTERRUPT 2
`define WCH_PIN_CLEAR_SW 3

// Reset values and counter saturation value
`define WCH_RST_PINS 4'h0
`define WCH_RST_CNT 14'h0000
`define WCH_CNT_SAT 14'h3FFF

// System clock period in ns
`define WCH_CLK_NS 20

// Handshake intervals in ns, taken at the computer end of the cable
`define WCH_T_OSETUP_MIN_NS 2600
`define WCH_T_OSETUP_MAX_NS 5600
`define WCH_T_IRESUME_MIN_NS 11200
`define WCH_T_IRESUME_MAX_NS 200000
`define WCH_T_ICLOSE_MIN_NS 1600
`define WCH_T_ICLOSE_MAX_NS 2800
`define WCH_T_OLEAD_MIN_NS 6200
`define WCH_T_OLEAD_MAX_NS 83000
`define WCH_T_OREACT_MIN_NS 1400
`define WCH_T_OREACT_MAX_NS 2800

// Least times round up, longest times round down
`define WCH_CYC_UP(ns) (((ns) + `WCH_CLK_NS - 1) / `WCH_CLK_NS)
`define WCH_CYC_DN(ns) ((ns) / `WCH_CLK_NS)

`endif

//--- pkg/wch_pkg.sv
`include "wch_map.svh"

package wch_pkg;

    // Input channel sequence, Gray coded in listed order from idle to close
    typedef enum logic [2:0] {
        WCH_I_IDLE = 3'h0,
        WCH_I_WAIT_RDY = 3'h1,
        WCH_I_ACCEPT = 3'h3,
        WCH_I_WAIT_DROP = 3'h2,
        WCH_I_CLOSE = 3'h6
    } wch_in_state_t;

    // Output channel sequence, Gray coded in listed order from idle to wait clear
    typedef enum logic [2:0] {
        WCH_O_IDLE = 3'h0,
        WCH_O_LEAD = 3'h1,
        WCH_O_LOAD = 3'h3,
        WCH_O_SETTLE = 3'h2,
        WCH_O_WAIT_RES = 3'h6,
        WCH_O_REACT = 3'h7,
        WCH_O_WAIT_CLR = 3'h5
    } wch_out_state_t;

    typedef struct packed {
        logic [`WCH_PIN_W-1:0] s1;
        logic [`WCH_PIN_W-1:0] s2;
        logic [`WCH_PIN_W-1:0] s3;
        logic [`WCH_PIN_W-1:0] q;
    } wch_sync_t;

    typedef struct packed {
        logic [`WCH_CNT_W-1:0] cnt;
    } wch_span_t;

    typedef struct packed {
        wch_in_state_t in_st;
        logic in_active;
        logic in_resume;
        logic [`WCH_LEN_W-1:0] in_left;
        logic [`WCH_DATA_W-1:0] in_word;
        logic in_word_valid;
        wch_out_state_t out_st;
        logic out_active;
        logic out_ready;
        logic out_take;
        logic out_first;
        logic [`WCH_LEN_W-1:0] out_left;
        logic [`WCH_DATA_W-1:0] out_data;
        logic master_clear;
        logic irq;
    } wch_state_t;

endpackage : wch_pkg

//--- hdl/wch_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "wch_map.svh"

module wch_sync
    import wch_pkg::*;
(
    input wire logic clk_in,                    // System clock
    input wire logic nrst_in,                   // Sync reset, active low
    input wire logic [`WCH_PIN_W-1:0] pins_in,  // Raw control pins
    output logic [`WCH_PIN_W-1:0] pins_out      // Filtered levels
);

    wch_sync_t st_reg;
    wch_sync_t st_next;
    logic [`WCH_PIN_W-1:0] agree;

    ////////////////////////////////////////////////////////////////////////
    // Three stages; a level counts once stages two and three agree.
    // Stage one feeds only stage two, so a metastable sample never
    // reaches the agreement logic.
    always_comb begin
        st_next = st_reg;
        agree = ~(st_reg.s2 ^ st_reg.s3);
        st_next.s1 = pins_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.q = (agree & st_reg.s3) | (~agree & st_reg.q);
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_reg <= '{`WCH_RST_PINS, `WCH_RST_PINS, `WCH_RST_PINS,
                        `WCH_RST_PINS};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins_out = st_reg.q;

endmodule : wch_sync
`default_nettype wire

//--- hdl/wch_span.sv
`timescale 1ns/1ps
`default_nettype none
`include "wch_map.svh"

module wch_span
    import wch_pkg::*;
(
    input wire logic clk_in,                   // System clock
    input wire logic nrst_in,                  // Sync reset, active low
    input wire logic restart_in,               // Start a new interval
    output logic [`WCH_CNT_W-1:0] count_out    // Cycles since restart
);

    wch_span_t st_reg;
    wch_span_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // Saturating so a long stall never wraps into a false short interval
    always_comb begin
        st_next = st_reg;
        if (restart_in) begin
            st_next.cnt = `WCH_RST_CNT;
        end else if (st_reg.cnt != `WCH_CNT_SAT) begin
            st_next.cnt = st_reg.cnt + `WCH_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_reg <= '{cnt: `WCH_RST_CNT};
        end else begin
            st_reg <= st_next;
        end
    end

    assign count_out = st_reg.cnt;

endmodule : wch_span
`default_nettype wire

//--- hdl/wch_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "wch_map.svh"

// Interface rules for this block and for the equipment
// (RL1) Words move as 48 parallel static levels in each direction.
// (RL2) Equipment drives zero on unused high input lines.
// (RL3) Undriven input lines read as zero; narrow receivers ignore high lines.
// (RL4) Output word sits on lines 2.6 to 5.6 us before output ready.
// (RL5) Input buffer active rises before any input word is exchanged.
// (RL6) Equipment places word and raises input ready, possibly together.
// (RL7) Input resume rises 11.2 to 200 us after the word is seen.
// (RL8) Equipment drops input ready on resume, then prepares next word.
// (RL9) Input resume falls after input ready is seen low.
// (RL10) Input resume falls 1.6 to 2.8 us after ready falls.
// (RL11) Repeat per word; input active drops on last ready's fall.
// (RL12) Output active rises, then each word loads the output register.
// (RL13) First output word follows output active by 6.2 to 83 us.
// (RL14) Equipment takes word at own pace, then raises output resume.
// (RL15) Output ready falls once output resume is seen.
// (RL16) Output ready falls 1.4 to 2.8 us after resume.
// (RL17) Equipment drops output resume after ready falls.
// (RL18) Repeat per word; output active drops on last resume's rise.
// (RL19) All intervals are taken at the computer end.
// (RL20) A cable group holds one input and one output channel.
// (RL21) Master clear line follows the console clear switch.
// (RL22) Equipment holds interrupt until deselected or cleared.
// (RL23) Equipment resynchronises every control signal but data.
// (RL24) Select with zero equipment code clears all equipment on channel.
// (RL25) Intervals are counted on the system clock against limits.
module wch_channel
    import wch_pkg::*;
#(
    parameter int IN_RESUME_MAX_CYC = `WCH_CYC_DN(`WCH_T_IRESUME_MAX_NS),
    parameter int OUT_LEAD_MAX_CYC = `WCH_CYC_DN(`WCH_T_OLEAD_MAX_NS)
)
(
    input wire logic clk_in,                          // 50 MHz clock
    input wire logic nrst_in,                         // Sync reset, low
    input wire logic in_start_in,                     // Start input block
    input wire logic [`WCH_LEN_W-1:0] in_words_in,    // Input block length
    output logic [`WCH_DATA_W-1:0] in_word_out,       // Received word
    output logic in_word_valid_out,                   // Received word pulse
    input wire logic out_start_in,                    // Start output block
    input wire logic [`WCH_LEN_W-1:0] out_words_in,   // Output block length
    input wire logic [`WCH_DATA_W-1:0] out_word_in,   // Next word to send
    input wire logic out_word_valid_in,               // Next word offered
    output logic out_word_ready_out,                  // Next word taken
    input wire logic clear_switch_in,                 // Console clear pin
    output logic irq_out,                             // Interrupt level
    input wire logic [`WCH_DATA_W-1:0] in_data_in,    // Input data lines
    input wire logic in_ready_in,                     // Input data ready
    output logic in_resume_out,                       // Input data resume
    output logic in_active_out,                       // Input buffer active
    output logic [`WCH_DATA_W-1:0] out_data_out,      // Output data lines
    output logic out_ready_out,                       // Output data ready
    input wire logic out_resume_in,                   // Output data resume
    output logic out_active_out,                      // Output buffer active
    output logic master_clear_out,                    // External master clr
    input wire logic interrupt_in                     // Interrupt line
);

    // (RL25) Limits as cycle counts
    localparam logic [`WCH_CNT_W-1:0] C_OSETUP_MIN =
        `WCH_CNT_W'(`WCH_CYC_UP(`WCH_T_OSETUP_MIN_NS));
    localparam logic [`WCH_CNT_W-1:0] C_OSETUP_MAX =
        `WCH_CNT_W'(`WCH_CYC_DN(`WCH_T_OSETUP_MAX_NS));
    localparam logic [`WCH_CNT_W-1:0] C_IRES_MIN =
        `WCH_CNT_W'(`WCH_CYC_UP(`WCH_T_IRESUME_MIN_NS));
    localparam logic [`WCH_CNT_W-1:0] C_ICLOSE_MIN =
        `WCH_CNT_W'(`WCH_CYC_UP(`WCH_T_ICLOSE_MIN_NS));
    localparam logic [`WCH_CNT_W-1:0] C_ICLOSE_MAX =
        `WCH_CNT_W'(`WCH_CYC_DN(`WCH_T_ICLOSE_MAX_NS));
    localparam logic [`WCH_CNT_W-1:0] C_OLEAD_MIN =
        `WCH_CNT_W'(`WCH_CYC_UP(`WCH_T_OLEAD_MIN_NS));
    localparam logic [`WCH_CNT_W-1:0] C_OREACT_MIN =
        `WCH_CNT_W'(`WCH_CYC_UP(`WCH_T_OREACT_MIN_NS));
    localparam logic [`WCH_CNT_W-1:0] C_OREACT_MAX =
        `WCH_CNT_W'(`WCH_CYC_DN(`WCH_T_OREACT_MAX_NS));

    wch_state_t st_reg;
    wch_state_t st_next;
    logic [`WCH_PIN_W-1:0] pins_raw;
    logic [`WCH_PIN_W-1:0] pins_s;
    logic [`WCH_CNT_W-1:0] in_cnt;
    logic [`WCH_CNT_W-1:0] out_cnt;
    logic in_restart;
    logic out_restart;
    logic rdy_s;
    logic res_s;
    logic clr_s;

    // True once an interval has run its least length
    function automatic logic reached(input logic [`WCH_CNT_W-1:0] cnt,
                                     input logic [`WCH_CNT_W-1:0] lim);
        reached = (cnt >= lim);
    endfunction : reached

    // Block length of zero is taken as a single word
    function automatic logic [`WCH_LEN_W-1:0] block_len(
        input logic [`WCH_LEN_W-1:0] n);
        block_len = (n == '0) ? `WCH_LEN_W'(1) : n;
    endfunction : block_len

    ////////////////////////////////////////////////////////////////////////
    // Control pins pass the three-stage filter; data lines do not,
    // they are only sampled once their ready has been filtered.
    always_comb begin
        pins_raw = `WCH_RST_PINS;
        pins_raw[`WCH_PIN_IN_READY] = in_ready_in;
        pins_raw[`WCH_PIN_OUT_RESUME] = out_resume_in;
        pins_raw[`WCH_PIN_INTERRUPT] = interrupt_in;
        pins_raw[`WCH_PIN_CLEAR_SW] = clear_switch_in;
    end

    wch_sync u_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .pins_in(pins_raw),
        .pins_out(pins_s)
    );

    assign rdy_s = pins_s[`WCH_PIN_IN_READY];
    assign res_s = pins_s[`WCH_PIN_OUT_RESUME];
    assign clr_s = pins_s[`WCH_PIN_CLEAR_SW];

    ////////////////////////////////////////////////////////////////////////
    // (RL19) Local interval counters
    wch_span u_in_span (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .restart_in(in_restart),
        .count_out(in_cnt)
    );

    wch_span u_out_span (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .restart_in(out_restart),
        .count_out(out_cnt)
    );

    // Restart at each edge an interval is timed from
    always_comb begin
        in_restart = ((st_reg.in_st == WCH_I_WAIT_RDY) && rdy_s) ||
                     ((st_reg.in_st == WCH_I_WAIT_DROP) && !rdy_s);
        out_restart = ((st_reg.out_st == WCH_O_IDLE) && out_start_in) ||
                      ((st_reg.out_st == WCH_O_LOAD) && st_reg.out_take &&
                       out_word_valid_in) ||
                      ((st_reg.out_st == WCH_O_WAIT_RES) && res_s);
    end

    ////////////////////////////////////////////////////////////////////////
    // (RL20) One input and one output channel of a cable group
    always_comb begin
        st_next = st_reg;
        st_next.in_word_valid = 1'b0;
        st_next.irq = pins_s[`WCH_PIN_INTERRUPT];
        // (RL21) Clear line follows switch
        st_next.master_clear = clr_s;

        // (RL5) Active precedes exchange
        unique case (st_reg.in_st)
            WCH_I_IDLE: begin
                if (in_start_in) begin
                    st_next.in_active = 1'b1;
                    st_next.in_left = block_len(in_words_in);
                    st_next.in_st = WCH_I_WAIT_RDY;
                end
            end
            WCH_I_WAIT_RDY: begin
                if (rdy_s) begin
                    // (RL3) Capture parallel word
                    st_next.in_word = in_data_in;
                    st_next.in_st = WCH_I_ACCEPT;
                end
            end
            WCH_I_ACCEPT: begin
                // (RL7) Resume after storage
                if (reached(in_cnt, C_IRES_MIN)) begin
                    st_next.in_resume = 1'b1;
                    st_next.in_word_valid = 1'b1;
                    st_next.in_st = WCH_I_WAIT_DROP;
                end
            end
            WCH_I_WAIT_DROP: begin
                // (RL11) Last fall ends block
                if (!rdy_s) begin
                    st_next.in_left = st_reg.in_left - `WCH_LEN_W'(1);
                    if (st_reg.in_left == `WCH_LEN_W'(1)) begin
                        st_next.in_active = 1'b0;
                    end
                    st_next.in_st = WCH_I_CLOSE;
                end
            end
            WCH_I_CLOSE: begin
                // (RL9) (RL10) Resume falls after ready
                if (reached(in_cnt, C_ICLOSE_MIN)) begin
                    st_next.in_resume = 1'b0;
                    st_next.in_st = st_reg.in_active ? WCH_I_WAIT_RDY
                                                     : WCH_I_IDLE;
                end
            end
            default: begin
                st_next.in_st = WCH_I_IDLE;
            end
        endcase

        // (RL12) Active first, then words
        unique case (st_reg.out_st)
            WCH_O_IDLE: begin
                if (out_start_in) begin
                    st_next.out_active = 1'b1;
                    st_next.out_first = 1'b1;
                    st_next.out_left = block_len(out_words_in);
                    st_next.out_st = WCH_O_LEAD;
                end
            end
            WCH_O_LEAD: begin
                // (RL13) Lead before first word
                if (reached(out_cnt, C_OLEAD_MIN)) begin
                    st_next.out_take = 1'b1;
                    st_next.out_st = WCH_O_LOAD;
                end
            end
            WCH_O_LOAD: begin
                // (RL1) Load output register
                if (st_reg.out_take && out_word_valid_in) begin
                    st_next.out_data = out_word_in;
                    st_next.out_take = 1'b0;
                    st_next.out_first = 1'b0;
                    st_next.out_st = WCH_O_SETTLE;
                end
            end
            WCH_O_SETTLE: begin
                // (RL4) Lines settle before ready
                if (reached(out_cnt, C_OSETUP_MIN)) begin
                    st_next.out_ready = 1'b1;
                    st_next.out_st = WCH_O_WAIT_RES;
                end
            end
            WCH_O_WAIT_RES: begin
                // (RL18) Last resume ends block
                if (res_s) begin
                    st_next.out_left = st_reg.out_left - `WCH_LEN_W'(1);
                    if (st_reg.out_left == `WCH_LEN_W'(1)) begin
                        st_next.out_active = 1'b0;
                    end
                    st_next.out_st = WCH_O_REACT;
                end
            end
            WCH_O_REACT: begin
                // (RL15) (RL16) Ready falls after resume
                if (reached(out_cnt, C_OREACT_MIN)) begin
                    st_next.out_ready = 1'b0;
                    st_next.out_st = WCH_O_WAIT_CLR;
                end
            end
            WCH_O_WAIT_CLR: begin
                // Next word only once the resume is gone
                if (!res_s) begin
                    st_next.out_take = st_reg.out_active;
                    st_next.out_st = st_reg.out_active ? WCH_O_LOAD
                                                       : WCH_O_IDLE;
                end
            end
            default: begin
                st_next.out_st = WCH_O_IDLE;
            end
        endcase

        // Console clear aborts both channels; the data lines keep
        // their last word because clearing them gains nothing.
        if (clr_s) begin
            st_next.in_st = WCH_I_IDLE;
            st_next.in_active = 1'b0;
            st_next.in_resume = 1'b0;
            st_next.in_word_valid = 1'b0;
            st_next.out_st = WCH_O_IDLE;
            st_next.out_active = 1'b0;
            st_next.out_ready = 1'b0;
            st_next.out_take = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_reg <= '{in_st: WCH_I_IDLE, out_st: WCH_O_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign in_word_out = st_reg.in_word;
    assign in_word_valid_out = st_reg.in_word_valid;
    assign in_resume_out = st_reg.in_resume;
    assign in_active_out = st_reg.in_active;
    assign out_data_out = st_reg.out_data;
    assign out_ready_out = st_reg.out_ready;
    assign out_active_out = st_reg.out_active;
    assign out_word_ready_out = st_reg.out_take;
    assign master_clear_out = st_reg.master_clear;
    assign irq_out = st_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the timing seen at the pins
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    dout_setup_a: assert property ( // (RL4)
        $rose(out_ready_out) |-> (out_cnt > C_OSETUP_MIN) &&
                                 (out_cnt <= C_OSETUP_MAX))
        else $error("out ready setup time");

    resume_wait_a: assert property ( // (RL7)
        $rose(in_resume_out) |-> (in_cnt > C_IRES_MIN) &&
                                 (in_cnt <= IN_RESUME_MAX_CYC))
        else $error("in resume response time");

    resume_drop_a: assert property ( // (RL9)
        $fell(in_resume_out) && !clr_s |-> !rdy_s)
        else $error("in resume fell with ready high");

    close_time_a: assert property ( // (RL10)
        $fell(in_resume_out) && !clr_s |-> (in_cnt > C_ICLOSE_MIN) &&
                                           (in_cnt <= C_ICLOSE_MAX))
        else $error("in resume close time");

    in_active_drop_a: assert property ( // (RL11)
        $fell(in_active_out) && !clr_s |-> !rdy_s && in_resume_out)
        else $error("in active fell early");

    lead_time_a: assert property ( // (RL13)
        out_word_ready_out && out_word_valid_in && st_reg.out_first |->
            (out_cnt > C_OLEAD_MIN) && out_active_out &&
            (out_cnt <= OUT_LEAD_MAX_CYC))
        else $error("first out word lead time");

    react_time_a: assert property ( // (RL16)
        $fell(out_ready_out) && !clr_s |-> (out_cnt > C_OREACT_MIN) &&
                                          (out_cnt <= C_OREACT_MAX) && res_s)
        else $error("out ready reaction time");

    out_active_drop_a: assert property ( // (RL18)
        $fell(out_active_out) && !clr_s |-> res_s && out_ready_out)
        else $error("out active fell early");

    clear_follow_a: assert property ( // (RL21)
        clr_s |=> master_clear_out && !in_active_out && !out_active_out)
        else $error("clear did not follow switch");

    ready_hold_a: assert property ( // (RL15)
        out_ready_out && !res_s && !clr_s |=> out_ready_out)
        else $error("out ready fell early");

    in_block_c: cover property ($fell(in_active_out) && !clr_s);
    out_block_c: cover property ($fell(out_active_out) && !clr_s);
    out_pair_c: cover property (
        out_active_out && $fell(out_ready_out) ##[1:400] $rose(out_ready_out));
    clear_c: cover property ($rose(master_clear_out) && in_active_out);

endmodule : wch_channel
`default_nettype wire

//--- tb/wch_equip.sv
`timescale 1ns/1ps
`default_nettype none
`include "wch_map.svh"

// Far-end equipment model
module wch_equip (
    input wire logic clk_in,                         // System clock
    input wire logic nrst_in,                        // Sync reset, low
    input wire logic send_in,                        // Offer word_in
    input wire logic [`WCH_DATA_W-1:0] word_in,      // Word to send
    input wire logic [7:0] dly_in,                   // Accept delay
    input wire logic in_resume_in,                   // Input resume pin
    input wire logic out_ready_in,                   // Output ready pin
    output logic [`WCH_DATA_W-1:0] in_data_out,      // Input data lines
    output logic in_ready_out,                       // Input ready pin
    output logic out_resume_out                      // Output resume pin
);
    logic [1:0] res_s;
    logic [1:0] rdy_s;
    logic [7:0] wait_reg;

    always_ff @(posedge clk_in) begin
        res_s <= {res_s[0], in_resume_in};
        rdy_s <= {rdy_s[0], out_ready_in};
        if (!nrst_in) begin
            in_ready_out <= 1'h0;
            in_data_out <= '0;
            out_resume_out <= 1'h0;
            wait_reg <= 8'h00;
        end else begin
            if (send_in) begin
                in_data_out <= word_in;
                in_ready_out <= 1'h1;
            end else if (in_ready_out && res_s[1]) begin
                in_ready_out <= 1'h0;
                // Released lines show a changed pattern, not stale data
                in_data_out <= ~in_data_out;
            end
            if (rdy_s[1] && !out_resume_out) begin
                if (wait_reg == dly_in) out_resume_out <= 1'h1;
                else wait_reg <= wait_reg + 8'h01;
            end else if (!rdy_s[1]) begin
                out_resume_out <= 1'h0;
                wait_reg <= 8'h00;
            end
        end
    end
endmodule : wch_equip
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "wch_map.svh"

module testbench;
    logic clk_in, nrst_in, in_start_in, out_start_in, eq_send;
    logic out_word_valid_in, clear_switch_in, interrupt_in;
    logic [`WCH_LEN_W-1:0] in_words_in, out_words_in;
    logic [`WCH_DATA_W-1:0] out_word_in, eq_word, in_data_in;
    logic [`WCH_DATA_W-1:0] in_word_out, out_data_out;
    logic [7:0] eq_dly;
    logic in_ready_in, out_resume_in, in_word_valid_out, out_word_ready_out;
    logic irq_out, in_resume_out, in_active_out, out_ready_out;
    logic out_active_out, master_clear_out;
    int err_count, total_checks;

    logic [6:0] mon;

    wch_channel i_dut (.*);

    wch_equip i_equip (.clk_in(clk_in), .nrst_in(nrst_in),
        .send_in(eq_send), .word_in(eq_word), .dly_in(eq_dly),
        .in_resume_in(in_resume_out), .out_ready_in(out_ready_out),
        .in_data_out(in_data_in), .in_ready_out(in_ready_in),
        .out_resume_out(out_resume_in));

    // Watched levels, indexed by wait_sig
    assign mon = {out_resume_in, in_ready_in, irq_out, master_clear_out,
        out_word_ready_out, out_ready_out, in_resume_out};

    ////////////////////////////////////////////////////////////////////////
    // Clock at 50 MHz
    initial begin
        clk_in = 1'h0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic report_and_stop;
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input string name, input logic [47:0] seen,
                         input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic rng(input string name, input int n, input int lo,
                       input int hi);
        check(name, 48'(n >= lo && n <= hi), 48'h1);
    endtask : rng

    // Edges until a watched signal reaches lvl
    task automatic wait_sig(input int sel, input logic lvl, output int n);
        logic v;
        n = 0;
        v = ~lvl;
        while (v !== lvl && n < 12000) begin
            @(posedge clk_in);
            #1;
            n++;
            v = mon[sel];
        end
        check("wait_level", 48'(v), 48'(lvl));
    endtask : wait_sig

    ////////////////////////////////////////////////////////////////////////
    // Two input words, first narrow
    task automatic t_input;
        int n;
        logic [47:0] w;
        @(posedge clk_in);
        in_words_in <= 16'h0002;
        in_start_in <= 1'h1;
        @(posedge clk_in);
        in_start_in <= 1'h0;
        #1;
        check("in_active", 48'(in_active_out), 48'h1);
        for (int k = 0; k < 2; k++) begin
            w = k ? 48'h8421FEDCBA98 : 48'h000000ABCDEF;
            @(posedge clk_in);
            eq_word <= w;
            eq_send <= 1'h1;
            @(posedge clk_in);
            eq_send <= 1'h0;
            wait_sig(0, 1'h1, n);
            rng("in_resume_rise", n, 560, 10000);
            check("in_valid", 48'(in_word_valid_out), 48'h1);
            check("in_word", in_word_out, w);
            wait_sig(5, 1'h0, n);
            wait_sig(0, 1'h0, n);
            rng("in_resume_fall", n, 80, 140);
            check("in_active_end", 48'(in_active_out), 48'(k == 0));
        end
    endtask : t_input

    // Two output words, prompt then slow equipment
    task automatic t_output;
        int n, t;
        @(posedge clk_in);
        out_words_in <= 16'h0002;
        out_start_in <= 1'h1;
        @(posedge clk_in);
        out_start_in <= 1'h0;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_in);
            out_word_in <= k ? 48'h123456789ABC : 48'hFEDCBA987654;
            out_word_valid_in <= 1'h1;
            eq_dly <= k ? 8'hC8 : 8'h01;
            wait_sig(2, 1'h1, t);
            @(posedge clk_in);
            out_word_valid_in <= 1'h0;
            wait_sig(1, 1'h1, n);
            rng("out_setup", n, 130, 280);
            check("out_data", out_data_out, out_word_in);
            if (k == 0) rng("out_lead", t + n + 2, 310, 4150);
            wait_sig(6, 1'h1, n);
            wait_sig(1, 1'h0, n);
            rng("out_react", n, 70, 140);
            check("out_active_end", 48'(out_active_out), 48'(k == 0));
            wait_sig(6, 1'h0, n);
        end
    endtask : t_output

    // Clear aborts channels; interrupt reported
    task automatic t_clear;
        int n;
        @(posedge clk_in);
        in_start_in <= 1'h1;
        out_start_in <= 1'h1;
        @(posedge clk_in);
        in_start_in <= 1'h0;
        out_start_in <= 1'h0;
        clear_switch_in <= 1'h1;
        wait_sig(3, 1'h1, n);
        rng("clear_rise", n, 1, 6);
        check("clear_idle", 48'({in_active_out, out_active_out}), 48'h0);
        @(posedge clk_in);
        clear_switch_in <= 1'h0;
        interrupt_in <= 1'h1;
        wait_sig(3, 1'h0, n);
        rng("clear_fall", n, 1, 6);
        wait_sig(4, 1'h1, n);
        @(posedge clk_in);
        interrupt_in <= 1'h0;
        wait_sig(4, 1'h0, n);
        rng("irq_fall", n, 1, 6);
    endtask : t_clear

    ////////////////////////////////////////////////////////////////////////
    // Run takes a few thousand cycles; limit is 20000
    initial begin
        #400000;
        err_count++;
        report_and_stop();
    end

    // Reset for 16 cycles, then the scenarios
    initial begin
        {nrst_in, in_start_in, out_start_in, eq_send, out_word_valid_in,
         clear_switch_in, interrupt_in, in_words_in, out_words_in} = '0;
        {out_word_in, eq_word, err_count, total_checks} = '0;
        eq_dly = 8'h01;
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'h1;
        @(posedge clk_in);
        #1;
        check("reset_idle", 48'({in_resume_out, in_active_out,
              out_ready_out, out_active_out, master_clear_out}), 48'h0);
        t_input();
        t_output();
        t_clear();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
